/* File: core/branch_cond_eval.sv */
// condition selector: picks the status flag test for one branch code
// assumes flags are stable in the cycle the code is presented
`timescale 1ns/1ps
`include "branch_unit_defs.svh"

module branch_cond_eval
    import branch_unit_pkg::*;
(
    input wire logic [`BR_OP_W-1:0] op,
    input wire status_t flags,
    output logic hit,
    output logic legal
);

    logic signed_lt;

    // signed compare result needs both negative and overflow
    assign signed_lt = flags.negative ^ flags.overflow;

    always_comb begin
        hit = 1'b0;
        legal = 1'b1;
        unique case (op)
            branch_on_equal: hit = flags.zero == 1'b1;
            branch_on_not_equal: hit = flags.zero == 1'b0;
            branch_on_carry_set: hit = flags.carry == 1'b1;
            branch_on_lower: hit = flags.carry == 1'b1;
            branch_on_carry_clear: hit = flags.carry == 1'b0;
            branch_on_same_or_higher: hit = flags.carry == 1'b0;
            branch_on_minus: hit = flags.negative == 1'b1;
            branch_on_plus: hit = flags.negative == 1'b0;
            branch_on_signed_ge: hit = signed_lt == 1'b0;
            branch_on_signed_lt: hit = signed_lt == 1'b1;
            branch_on_half_carry_set: hit = flags.half_carry == 1'b1;
            branch_on_half_carry_clear: hit = flags.half_carry == 1'b0;
            branch_on_user_bit_set: hit = flags.user_bit == 1'b1;
            branch_on_user_bit_clear: hit = flags.user_bit == 1'b0;
            branch_on_overflow_set: hit = flags.overflow == 1'b1;
            branch_on_overflow_clear: hit = flags.overflow == 1'b0;
            branch_on_irq_enabled: hit = flags.irq_enable == 1'b1;
            branch_on_irq_disabled: hit = flags.irq_enable == 1'b0;
            default: begin
                // unused codes never branch
                hit = 1'b0;
                legal = 1'b0;
            end
        endcase
    end

endmodule : branch_cond_eval

/* File: core/branch_target_adder.sv */
// relative target adder: pc + sign-extended offset + 1
// assumes pc counts instruction words and wraps at its width
`timescale 1ns/1ps
`include "branch_unit_defs.svh"

module branch_target_adder #(
    parameter int PC_W = `BR_PC_W,
    parameter int OFF_W = `BR_OFFSET_W
) (
    input wire logic [PC_W-1:0] pc,
    input wire logic [OFF_W-1:0] offset,
    output logic [PC_W-1:0] target
);

    logic [PC_W-1:0] offset_ext;

    initial begin
        if (OFF_W < 2 || OFF_W >= PC_W) begin
            $error("branch_target_adder: offset width must be 2 .. PC_W-1");
        end
    end

    // sign bit replicated so negative offsets reach back
    assign offset_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};

    // modulo add, wrap at the top of program space is intended
    assign target = pc + offset_ext + {{(PC_W-1){1'b0}}, 1'b1};

endmodule : branch_target_adder

/* File: core/branch_unit.sv */
// conditional relative branch unit of the core's execute stage
// assumes the fetch stage presents the current pc of the branch word,
// advances the pc itself on fall-through, and holds the request while
// req_ready is low
`timescale 1ns/1ps
`include "branch_unit_defs.svh"

// Summary of operation
// - equal branch jumps to pc plus offset plus one when zero is set
// - not-equal branch jumps when zero is clear, else falls through
// - carry-set and lower branches jump when carry is set
// - carry-clear and same-or-higher branches jump when carry is clear
// - minus branch jumps when negative is set
// - plus branch jumps when negative is clear
// - signed greater-or-equal jumps when negative xor overflow is zero
// - signed less-than jumps when negative xor overflow is one
// - half-carry-set branch jumps when half carry is set
// - half-carry-clear branch jumps when half carry is clear
// - user-bit-set branch jumps when the user transfer bit is set
// - user-bit-clear branch jumps when the user transfer bit is clear
// - overflow-set branch jumps when overflow is set
// - overflow-clear branch jumps when overflow is clear
// - interrupts-enabled branch jumps when global interrupt enable is set
// - every branch completes in one or two clock cycles
// - branches never change any status flag
// - interrupts-disabled branch jumps when global interrupt enable is clear
module branch_unit
    import branch_unit_pkg::*;
#(
    parameter int PC_W = `BR_PC_W,
    parameter int OFF_W = `BR_OFFSET_W,
    parameter int CNT_W = `BR_CNT_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire branch_req_t req,
    input wire logic [PC_W-1:0] pc_in,
    input wire status_t flags_in,
    output logic req_ready,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    output logic fetch_flush,
    output branch_resp_t resp,
    output status_t flags_out,
    output logic flags_write,
    output logic [CNT_W-1:0] taken_count,
    output logic [CNT_W-1:0] fall_count
);

    initial begin
        if (PC_W < 2 || PC_W > 32) begin
            $error("branch_unit: PC_W must lie in 2 .. 32");
        end
        if (OFF_W != `BR_OFFSET_W) begin
            $error("branch_unit: request struct carries a fixed offset width");
        end
        if (CNT_W < 1) begin
            $error("branch_unit: CNT_W must be at least 1");
        end
        if (`BR_CYCLES_NOT_TAKEN != 1 || `BR_CYCLES_TAKEN != 2) begin
            $error("branch_unit: state machine serves one or two cycles only");
        end
    end

    branch_state_t state;
    branch_state_t next_state;

    logic accept;
    logic cond_hit;
    logic cond_legal;
    logic take_now;
    logic [PC_W-1:0] target_sum;
    logic [PC_W-1:0] held_target;
    logic held_illegal;

    // ---------------------------------------------------------------
    // condition and target, both evaluated in the accept cycle
    // ---------------------------------------------------------------

    branch_cond_eval u_cond (
        .op(req.op),
        .flags(flags_in),
        .hit(cond_hit),
        .legal(cond_legal)
    );

    branch_target_adder #(
        .PC_W(PC_W),
        .OFF_W(OFF_W)
    ) u_target (
        .pc(pc_in),
        .offset(req.offset),
        .target(target_sum)
    );

    assign accept = req.valid && req_ready;

    // an unused code is reported and treated as a fall-through
    assign take_now = accept && cond_hit && cond_legal;

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (take_now) begin
                    next_state = st_redirect;
                end
            end
            st_redirect: begin
                next_state = st_finish;
            end
            st_finish: begin
                if (take_now) begin
                    next_state = st_redirect;
                end else begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // stalls fetch for exactly the one extra cycle of a taken branch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= !take_now;
        end
    end

    // ---------------------------------------------------------------
    // target and flush toward fetch
    // ---------------------------------------------------------------

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            held_target <= PC_W'(`BR_PC_RESET);
        end else if (take_now) begin
            held_target <= target_sum;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_target <= PC_W'(`BR_PC_RESET);
        end else if (take_now) begin
            pc_target <= target_sum;
        end
    end

    // one-cycle load pulse; fall-through leaves pc stepping to fetch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_load <= 1'b0;
        end else begin
            pc_load <= take_now;
        end
    end

    // the word fetched behind a taken branch is discarded
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetch_flush <= 1'b0;
        end else begin
            fetch_flush <= take_now;
        end
    end

    // ---------------------------------------------------------------
    // completion report
    // ---------------------------------------------------------------

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            held_illegal <= 1'b0;
        end else if (accept) begin
            held_illegal <= !cond_legal;
        end
    end

    // done one edge after a fall-through, two after a taken branch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resp <= '0;
        end else begin
            resp.done <= (accept && !take_now) || (state == st_redirect);
            resp.taken <= (state == st_redirect);
            resp.illegal <= accept && !cond_legal;
        end
    end

    // ---------------------------------------------------------------
    // status flags are passed through untouched
    // ---------------------------------------------------------------

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_out <= `BR_STATUS_RESET;
        end else begin
            flags_out <= flags_in;
        end
    end

    // write strobe to the status register never fires from here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_write <= 1'b0;
        end else begin
            flags_write <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // outcome counters, wrap silently
    // ---------------------------------------------------------------

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            taken_count <= '0;
        end else if (state == st_redirect) begin
            taken_count <= taken_count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fall_count <= '0;
        end else if (accept && !take_now) begin
            fall_count <= fall_count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule : branch_unit

/* File: core/branch_unit_defs.svh */
// constants for the conditional relative branch unit
// assumes inclusion by bare name from the package and the design modules
`ifndef BRANCH_UNIT_DEFS_SVH
`define BRANCH_UNIT_DEFS_SVH

// program counter and offset widths (words), branch code width and counter width
`define BR_PC_W 16
`define BR_OFFSET_W 7
`define BR_OP_W 5
`define BR_CNT_W 16

// status register bit positions
`define BR_FLAG_C 0
`define BR_FLAG_Z 1
`define BR_FLAG_N 2
`define BR_FLAG_V 3
`define BR_FLAG_S 4
`define BR_FLAG_H 5
`define BR_FLAG_T 6
`define BR_FLAG_I 7

// cycles per branch outcome
`define BR_CYCLES_NOT_TAKEN 1
`define BR_CYCLES_TAKEN 2

// reset values
`define BR_PC_RESET 16'h0000
`define BR_STATUS_RESET 8'h00

`endif

/* File: core/branch_unit_pkg.sv */
// types shared by the branch unit modules
// assumes branch_unit_defs.svh is on the include path
`include "branch_unit_defs.svh"

package branch_unit_pkg;

    typedef enum logic [`BR_OP_W-1:0] {
        branch_on_equal            = 5'h00,
        branch_on_not_equal        = 5'h01,
        branch_on_carry_set        = 5'h02,
        branch_on_carry_clear      = 5'h03,
        branch_on_same_or_higher   = 5'h04,
        branch_on_lower            = 5'h05,
        branch_on_minus            = 5'h06,
        branch_on_plus             = 5'h07,
        branch_on_signed_ge        = 5'h08,
        branch_on_signed_lt        = 5'h09,
        branch_on_half_carry_set   = 5'h0A,
        branch_on_half_carry_clear = 5'h0B,
        branch_on_user_bit_set     = 5'h0C,
        branch_on_user_bit_clear   = 5'h0D,
        branch_on_overflow_set     = 5'h0E,
        branch_on_overflow_clear   = 5'h0F,
        branch_on_irq_enabled      = 5'h10,
        branch_on_irq_disabled     = 5'h11
    } branch_op_t;

    // status register, bit 7 down to bit 0
    typedef struct packed {
        logic irq_enable;
        logic user_bit;
        logic half_carry;
        logic sign;
        logic overflow;
        logic negative;
        logic zero;
        logic carry;
    } status_t;

    typedef struct packed {
        logic valid;
        logic [`BR_OP_W-1:0] op;
        logic [`BR_OFFSET_W-1:0] offset;
    } branch_req_t;

    typedef struct packed {
        logic done;
        logic taken;
        logic illegal;
    } branch_resp_t;

    typedef enum logic [2:0] {
        st_idle   = 3'b001,
        st_redirect = 3'b010,
        st_finish = 3'b100
    } branch_state_t;

endpackage : branch_unit_pkg

/* File: testbench/branch_unit_assertions.sv */
// port checker for the branch unit
// assumes it is bound onto every branch_unit instance
`timescale 1ns/1ps
module branch_unit_checker
    import branch_unit_pkg::*;
#(
    parameter int PC_W = 16,
    parameter int OFF_W = 7,
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire branch_req_t req,
    input wire logic [PC_W-1:0] pc_in,
    input wire status_t flags_in,
    input wire logic req_ready,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic fetch_flush,
    input wire branch_resp_t resp,
    input wire status_t flags_out,
    input wire logic flags_write,
    input wire logic [CNT_W-1:0] taken_count,
    input wire logic [CNT_W-1:0] fall_count
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic acc;
    assign acc = req.valid && req_ready;

    a_no_flag_write: assert property (!flags_write)
        else $error("flag write raised");
    a_flags_passed: assert property (!$past(rst) |-> flags_out == $past(flags_in))
        else $error("flags altered");
    a_flush_with_load: assert property (pc_load == fetch_flush)
        else $error("flush and load differ");
    a_taken_done: assert property (pc_load |=> resp.done && resp.taken && req_ready)
        else $error("taken branch not done in two cycles");
    a_load_stalls: assert property (pc_load |-> !req_ready)
        else $error("ready during redirect");
    a_one_answer: assert property (acc |=> (resp.done && !resp.taken) != pc_load)
        else $error("no single answer after accept");
    a_target_math: assert property (pc_load |-> pc_target == PC_W'($past(pc_in)
        + PC_W'($signed($past(req.offset))) + 1'b1))
        else $error("target wrong");
    a_not_equal: assert property (acc && req.op == 5'h01 |=>
        pc_load == !$past(flags_in.zero))
        else $error("not-equal outcome wrong");
    a_signed_ge: assert property (acc && req.op == 5'h08 |=>
        pc_load == !($past(flags_in.negative) ^ $past(flags_in.overflow)))
        else $error("signed ge outcome wrong");
    a_illegal_op: assert property (acc && req.op > 5'h11 |=>
        resp.illegal && resp.done && !pc_load)
        else $error("illegal code not refused");
endmodule : branch_unit_checker

bind branch_unit branch_unit_checker #(.PC_W(PC_W), .OFF_W(OFF_W), .CNT_W(CNT_W))
    branch_unit_checker_inst (.core_clk(core_clk), .rst(rst), .req(req), .pc_in(pc_in),
    .flags_in(flags_in), .req_ready(req_ready), .pc_load(pc_load), .pc_target(pc_target),
    .fetch_flush(fetch_flush), .resp(resp), .flags_out(flags_out),
    .flags_write(flags_write), .taken_count(taken_count), .fall_count(fall_count));

/* File: testbench/testbench.sv */
// self-checking bench for the branch unit
// assumes the port checker is bound from its own file
`timescale 1ns/1ps
module testbench
    import branch_unit_pkg::*;
;
    typedef struct packed {
        logic taken;
        logic illegal;
        logic [15:0] target;
    } note_t;
    logic core_clk;
    logic rst;
    branch_req_t req;
    logic [15:0] pc_in;
    status_t flags_in;
    logic req_ready, pc_load, fetch_flush, flags_write;
    logic [15:0] pc_target, taken_count, fall_count;
    branch_resp_t resp;
    status_t flags_out;
    note_t notes[$];
    note_t n;
    int err_total, comparisons, exp_taken, exp_fall;
    int seed = 32'h627f_8441;

    branch_unit branch_unit_inst (.core_clk(core_clk), .rst(rst), .req(req), .pc_in(pc_in),
        .flags_in(flags_in), .req_ready(req_ready), .pc_load(pc_load),
        .pc_target(pc_target), .fetch_flush(fetch_flush), .resp(resp),
        .flags_out(flags_out), .flags_write(flags_write), .taken_count(taken_count),
        .fall_count(fall_count));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic hit(input logic [4:0] op, input status_t f);
        case (op)
            5'h00: hit = f.zero;
            5'h01: hit = !f.zero;
            5'h02, 5'h05: hit = f.carry;
            5'h03, 5'h04: hit = !f.carry;
            5'h06: hit = f.negative;
            5'h07: hit = !f.negative;
            5'h08: hit = !(f.negative ^ f.overflow);
            5'h09: hit = f.negative ^ f.overflow;
            5'h0A: hit = f.half_carry;
            5'h0B: hit = !f.half_carry;
            5'h0C: hit = f.user_bit;
            5'h0D: hit = !f.user_bit;
            5'h0E: hit = f.overflow;
            5'h0F: hit = !f.overflow;
            5'h10: hit = f.irq_enable;
            5'h11: hit = !f.irq_enable;
            default: hit = 1'b0;
        endcase
    endfunction : hit

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, want);
        end
    endtask : check

    // entered just after a falling edge; holds the request until accepted
    task automatic issue(input logic [4:0] op, input logic [6:0] off,
                         input logic [15:0] pc, input status_t f);
        note_t e;
        int k;
        e.illegal = op > 5'h11;
        e.taken = hit(op, f);
        e.target = pc + {{9{off[6]}}, off} + 16'h0001;
        notes.push_back(e);
        if (e.taken) exp_taken++;
        else exp_fall++;
        req = '{valid: 1'b1, op: op, offset: off};
        pc_in = pc;
        flags_in = f;
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
    endtask : issue

    always @(negedge core_clk) begin
        if (!rst && pc_load === 1'b1) check(pc_target, notes[0].target);
        if (!rst && resp.done === 1'b1) begin
            n = notes.pop_front();
            check({resp.taken, resp.illegal}, {n.taken, n.illegal});
        end
    end

    task automatic finish_test;
        $display("comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    initial begin
        #200_000;
        err_total++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        pc_in = '0;
        flags_in = '0;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        // every code, both flag levels, offset extremes with pc wrap
        for (int op = 0; op < 32; op++) begin
            for (int b = 0; b < 2; b++) begin
                issue(5'(op), b ? 7'h40 : 7'h3f, b ? 16'h0000 : 16'hffff, b ? 8'hff : 8'h00);
            end
        end
        repeat (300) begin
            issue(5'($random(seed)), 7'($random(seed)), 16'($random(seed)), 8'($random(seed)));
            if (($random(seed) & 3) == 0) begin
                req.valid = 1'b0;
                @(negedge core_clk);
            end
        end
        req.valid = 1'b0;
        repeat (4) @(negedge core_clk);
        check(taken_count, exp_taken);
        check(fall_count, exp_fall);
        // reset lands in the redirect cycle of a taken branch
        issue(5'h00, 7'h05, 16'h0100, 8'h02);
        #5 rst = 1'b1;
        req.valid = 1'b0;
        #1 check({req_ready, pc_load, taken_count, fall_count}, 0);
        notes.delete();
        exp_taken = 0;
        exp_fall = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        issue(5'h10, 7'h7f, 16'h0200, 8'h80);
        issue(5'h11, 7'h01, 16'h0300, 8'h80);
        req.valid = 1'b0;
        repeat (4) @(negedge core_clk);
        check(taken_count, exp_taken);
        check(fall_count, exp_fall);
        finish_test();
    end
endmodule : testbench
